// file: inc/clk_rst_pkg.sv
// shared constants and types of the clock and reset sequencer
package clk_rst_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFS_PWR_CTL   = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    // power_mgmt_control field layout
    localparam int          MULT_LSB      = 0;
    localparam int          MULT_W        = 6;
    localparam int          DIV_LSB       = 6;
    localparam int          DIV_W         = 2;
    localparam int          CLKSEL_BIT    = 8;
    localparam int          OUTSEL_BIT    = 12;
    localparam logic [1:0]  DIV_RESET     = 2'h0;
    localparam logic        OUTSEL_RESET  = 1'b0;
    // status field layout
    localparam int          ST_RUN_BIT    = 0;
    localparam int          ST_RATIO_LSB  = 1;
    // ratio-select encodings and the core-to-reference ratios they give
    localparam logic [1:0]  RATIO_3       = 2'h0;
    localparam logic [1:0]  RATIO_16      = 2'h1;
    localparam logic [1:0]  RATIO_8       = 2'h2;
    localparam logic [5:0]  MULT_3        = 6'h03;
    localparam logic [5:0]  MULT_16       = 6'h10;
    localparam logic [5:0]  MULT_8        = 6'h08;
    localparam logic [5:0]  MULT_BYPASS   = 6'h01;
    localparam int          LOCK_CYCLES   = 4096;
    localparam int          LOCK_CNT_W    = 13;
    localparam int          IR_W          = 4;
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;
    localparam int          BSR_LEN       = 16;

    typedef enum logic [2:0] {
        SEQ_STRAP = 3'b001,
        SEQ_LOCK  = 3'b010,
        SEQ_RUN   = 3'b100
    } seq_t;

    typedef enum logic [15:0] {
        TAP_RESET   = 16'h0001,
        TAP_IDLE    = 16'h0002,
        TAP_SEL_DR  = 16'h0004,
        TAP_CAP_DR  = 16'h0008,
        TAP_SH_DR   = 16'h0010,
        TAP_EX1_DR  = 16'h0020,
        TAP_PAU_DR  = 16'h0040,
        TAP_EX2_DR  = 16'h0080,
        TAP_UPD_DR  = 16'h0100,
        TAP_SEL_IR  = 16'h0200,
        TAP_CAP_IR  = 16'h0400,
        TAP_SH_IR   = 16'h0800,
        TAP_EX1_IR  = 16'h1000,
        TAP_PAU_IR  = 16'h2000,
        TAP_EX2_IR  = 16'h4000,
        TAP_UPD_IR  = 16'h8000
    } tap_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jtag_in_t;
endpackage : clk_rst_pkg

// file: core/clock_reset_sequencer.sv
// clock selection, start-up ratio, reset sequencing, shared output pin and test port
// Notes on behaviour
// RQ1: core clock source is PLL or reference directly, picked by ratio pins.
// RQ2: start-up core frequency comes from ratio pins sampled at reset release.
// RQ3: after core reset ends, software may rewrite PLL multiplier and divider.
// RQ4: control bit 12 picks PLL clock or reset-out on shared pin; default reset-out.
// RQ5: in reset-out function the shared pin carries the core reset state.
// RQ6: after reset release wait 4096 reference cycles, then start at reset vector.
// RQ7: board holds the active-low reset asserted during power-up.
// RQ8: reference clock runs continuously, never halted, changed or too slow.
// RQ9: test reset clears the test state machine; board pulses or holds it low.
// RQ10: board pulses test clock low after power-up or holds it low.
// RQ11: test state machine follows mode-select sampled on test clock rising edges.
// RQ12: scan data shifts in from test data input; chain end drives test data output.
// RQ13: ratio pins 00 gives 3:1, 01 16:1, 10 8:1, 11 reserved.
// RQ14: core reset and reset-out stay asserted for the whole lock wait.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module clock_reset_sequencer
    import clk_rst_pkg::*;
#(
    parameter int          LOCK_WAIT    = clk_rst_pkg::LOCK_CYCLES,
    parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
)(
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rstn,
    input  wire logic [1:0]                    i_ratio_select_pins,
    input  wire clk_rst_pkg::bus_req_t         i_bus,
    input  wire clk_rst_pkg::jtag_in_t         i_jtag,
    output logic [clk_rst_pkg::DATA_W-1:0]     o_rdata,
    output logic                               o_core_rstn,
    output logic                               o_exec_start,
    output logic [31:0]                        o_exec_vector,
    output logic                               o_core_clk_pll,
    output logic [clk_rst_pkg::MULT_W-1:0]     o_pll_mult,
    output logic [clk_rst_pkg::DIV_W-1:0]      o_pll_div,
    output logic                               o_shared_out_pin,
    output logic                               o_tdo,
    output logic                               o_tdo_oe
);
    import clk_rst_pkg::*;

    typedef struct packed {
        seq_t                  seq;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic                  core_rstn;
        logic                  exec_start;
        logic [1:0]            ratio;
        logic [MULT_W-1:0]     mult;
        logic [DIV_W-1:0]      div;
        logic                  clk_pll;
        logic                  out_sel;
        logic                  pll_phase;
        logic                  shared_pin;
        logic [DATA_W-1:0]     rdata;
        tap_t                  tap;
        logic                  tck_q;
        logic [IR_W-1:0]       ir;
        logic [BSR_LEN-1:0]    bsr;
        logic                  tdo;
        logic                  tdo_oe;
    } state_t;

    localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_WAIT - 1);

    state_t st_r;
    state_t st_nxt;

    function automatic logic [MULT_W-1:0] ratio_to_mult(input logic [1:0] sel);
        case (sel)
            RATIO_3:  ratio_to_mult = MULT_3;
            RATIO_16: ratio_to_mult = MULT_16;
            RATIO_8:  ratio_to_mult = MULT_8;
            default:  ratio_to_mult = MULT_BYPASS;
        endcase
    endfunction : ratio_to_mult

    function automatic tap_t tap_step(input tap_t cur, input logic tms);
        case (cur)
            TAP_RESET:  tap_step = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_step = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_step = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_step = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_step = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_step = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_step = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_step = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: tap_step = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_step = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_step = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_step = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_step = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
            default:    tap_step = TAP_RESET;
        endcase
    endfunction : tap_step

    always_comb
    begin
        logic tck_rise;
        logic tck_fall;
        tck_rise = i_jtag.tck & ~st_r.tck_q;
        tck_fall = ~i_jtag.tck & st_r.tck_q;
        st_nxt = st_r;
        st_nxt.exec_start = 1'b0;
        st_nxt.rdata = '0;
        st_nxt.tck_q = i_jtag.tck;
        // stand-in for the PLL output; the real clock comes from the analog macro
        st_nxt.pll_phase = ~st_r.pll_phase;

        case (st_r.seq)
            SEQ_STRAP:
            begin
                // straps are caught on the first edge after release, never under reset
                st_nxt.ratio = i_ratio_select_pins;                         // RQ2
                st_nxt.mult = ratio_to_mult(i_ratio_select_pins);           // RQ13
                st_nxt.clk_pll = (i_ratio_select_pins != 2'h3);             // RQ1
                st_nxt.lock_cnt = '0;
                st_nxt.seq = SEQ_LOCK;
            end
            SEQ_LOCK:
            begin
                if (st_r.lock_cnt == LOCK_LAST)                             // RQ6
                begin
                    st_nxt.seq = SEQ_RUN;
                    st_nxt.core_rstn = 1'b1;                                // RQ14
                    st_nxt.exec_start = 1'b1;
                end
                else
                begin
                    st_nxt.lock_cnt = st_r.lock_cnt + 1'b1;
                end
            end
            SEQ_RUN:
            begin
                st_nxt.core_rstn = 1'b1;
            end
            default:
            begin
                st_nxt.seq = SEQ_STRAP;
                st_nxt.core_rstn = 1'b0;
            end
        endcase

        if (i_bus.wr)
        begin
            if (i_bus.addr == OFS_PWR_CTL)
            begin
                st_nxt.out_sel = i_bus.wdata[OUTSEL_BIT];                   // RQ4
                // frequency stays at the strap setting until the core is running
                if (st_r.seq == SEQ_RUN)                                    // RQ3
                begin
                    st_nxt.mult = i_bus.wdata[MULT_LSB +: MULT_W];
                    st_nxt.div = i_bus.wdata[DIV_LSB +: DIV_W];
                    st_nxt.clk_pll = i_bus.wdata[CLKSEL_BIT];
                end
            end
        end
        else if (i_bus.rd)
        begin
            if (i_bus.addr == OFS_PWR_CTL)
            begin
                st_nxt.rdata[MULT_LSB +: MULT_W] = st_r.mult;
                st_nxt.rdata[DIV_LSB +: DIV_W] = st_r.div;
                st_nxt.rdata[CLKSEL_BIT] = st_r.clk_pll;
                st_nxt.rdata[OUTSEL_BIT] = st_r.out_sel;
            end
            else if (i_bus.addr == OFS_STATUS)
            begin
                st_nxt.rdata[ST_RUN_BIT] = (st_r.seq == SEQ_RUN);
                st_nxt.rdata[ST_RATIO_LSB +: 2] = st_r.ratio;
            end
        end

        st_nxt.shared_pin = st_nxt.out_sel ? st_nxt.pll_phase : st_nxt.core_rstn; // RQ5

        if (!i_jtag.trst_n)                                                 // RQ9
        begin
            st_nxt.tap = TAP_RESET;
            st_nxt.tdo_oe = 1'b0;
        end
        else if (tck_rise)
        begin
            st_nxt.tap = tap_step(st_r.tap, i_jtag.tms);                    // RQ11
            case (st_r.tap)
                TAP_CAP_IR: st_nxt.ir = IR_CAPTURE;
                TAP_SH_IR:  st_nxt.ir = {i_jtag.tdi, st_r.ir[IR_W-1:1]};
                TAP_SH_DR:  st_nxt.bsr = {i_jtag.tdi, st_r.bsr[BSR_LEN-1:1]}; // RQ12
                default:    st_nxt.ir = st_r.ir;
            endcase
        end
        else if (tck_fall)
        begin
            // output changes on the falling edge so the far end samples a settled bit
            st_nxt.tdo_oe = (st_r.tap == TAP_SH_DR) || (st_r.tap == TAP_SH_IR);
            st_nxt.tdo = (st_r.tap == TAP_SH_IR) ? st_r.ir[0] : st_r.bsr[0]; // RQ12
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_r.seq        <= SEQ_STRAP;
            st_r.lock_cnt   <= '0;
            st_r.core_rstn  <= 1'b0;                                        // RQ14
            st_r.exec_start <= 1'b0;
            st_r.ratio      <= 2'h0;
            st_r.mult       <= MULT_3;
            st_r.div        <= DIV_RESET;
            st_r.clk_pll    <= 1'b1;
            st_r.out_sel    <= OUTSEL_RESET;                                // RQ4
            st_r.pll_phase  <= 1'b0;
            st_r.shared_pin <= 1'b0;                                        // RQ5
            st_r.rdata      <= '0;
            st_r.tap        <= TAP_RESET;
            st_r.tck_q      <= 1'b0;
            st_r.ir         <= IR_CAPTURE;
            st_r.bsr        <= '0;
            st_r.tdo        <= 1'b0;
            st_r.tdo_oe     <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata          = st_r.rdata;
    assign o_core_rstn      = st_r.core_rstn;
    assign o_exec_start     = st_r.exec_start;
    assign o_exec_vector    = RESET_VECTOR;
    assign o_core_clk_pll   = st_r.clk_pll;
    assign o_pll_mult       = st_r.mult;
    assign o_pll_div        = st_r.div;
    assign o_shared_out_pin = st_r.shared_pin;
    assign o_tdo            = st_r.tdo;
    assign o_tdo_oe         = st_r.tdo_oe;
endmodule : clock_reset_sequencer

// file: sim/clk_rst_chk.sv
// port-level assertions for the clock and reset sequencer
`timescale 1ns/1ps
module clk_rst_chk
    import clk_rst_pkg::*;
#(
    parameter int          LOCK_WAIT    = clk_rst_pkg::LOCK_CYCLES,
    parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
)(
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    input  wire clk_rst_pkg::bus_req_t i_bus,
    input  wire logic [DATA_W-1:0]     o_rdata,
    input  wire logic                  o_core_rstn,
    input  wire logic                  o_exec_start,
    input  wire logic [31:0]           o_exec_vector,
    input  wire logic                  o_core_clk_pll,
    input  wire logic [MULT_W-1:0]     o_pll_mult,
    input  wire logic [DIV_W-1:0]      o_pll_div,
    input  wire logic                  o_shared_out_pin
);
    int   wait_r;
    logic sel_r;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // wait_r counts edges spent with the core held; sel_r shadows the pin function bit
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wait_r <= 0;
            sel_r  <= OUTSEL_RESET;
        end
        else
        begin
            if (!o_core_rstn)
                wait_r <= wait_r + 1;
            if (i_bus.wr && i_bus.addr == OFS_PWR_CTL)
                sel_r <= i_bus.wdata[OUTSEL_BIT];
        end
    end
    AST_LOCK_WAIT: assert property ($rose(o_core_rstn) |-> wait_r == LOCK_WAIT + 1)
        else $error("core released after wrong wait");
    AST_LOCK_BOUND: assert property (wait_r <= LOCK_WAIT + 1)
        else $error("core held past lock wait");
    AST_EXEC_PULSE: assert property (o_exec_start == $rose(o_core_rstn))
        else $error("start pulse not tied to core release");
    AST_EXEC_VEC: assert property (o_exec_start |-> o_exec_vector == RESET_VECTOR)
        else $error("start vector wrong");
    AST_RESET_OUT: assert property (!sel_r |-> o_shared_out_pin == o_core_rstn)
        else $error("shared pin not following core reset");
    AST_PLL_TOGGLE: assert property (sel_r && $past(sel_r) |-> o_shared_out_pin != $past(o_shared_out_pin))
        else $error("shared pin not clocking");
    AST_MULT_HOLD: assert property (wait_r >= 2 && !o_core_rstn |-> $stable({o_core_clk_pll, o_pll_div, o_pll_mult}))
        else $error("pll settings moved during lock wait");
    AST_PLL_WRITE: assert property (o_core_rstn && i_bus.wr && i_bus.addr == OFS_PWR_CTL |=>
        {o_core_clk_pll, o_pll_div, o_pll_mult} == $past(i_bus.wdata[8:0]))
        else $error("pll write not applied");
    AST_RUN_STATUS: assert property ($past(i_bus.rd) && $past(i_bus.addr) == OFS_STATUS |->
        o_rdata[ST_RUN_BIT] == $past(o_core_rstn))
        else $error("status run bit wrong");
    cover property ($rose(o_core_rstn));
    cover property (sel_r && o_shared_out_pin);
    cover property (o_core_rstn && i_bus.wr && i_bus.addr == OFS_PWR_CTL);
endmodule : clk_rst_chk

bind clock_reset_sequencer clk_rst_chk #(.LOCK_WAIT(LOCK_WAIT), .RESET_VECTOR(RESET_VECTOR)) u_chk (
    .i_clk_sys, .i_rstn, .i_bus, .o_rdata, .o_core_rstn, .o_exec_start, .o_exec_vector,
    .o_core_clk_pll, .o_pll_mult, .o_pll_div, .o_shared_out_pin);

// file: sim/jtag_host.sv
// board-side test port host: test clock, mode select, data in and test reset
`timescale 1ns/1ps
module jtag_host
    import clk_rst_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_tdo,
    input  wire logic             i_tdo_oe,
    output clk_rst_pkg::jtag_in_t o_jtag
);
    // test clock rests low, test reset held low from power-up, pull-ups on mode and data
    initial o_jtag = '{1'b0, 1'b1, 1'b1, 1'b0};
    task automatic set_trst(input logic v);
        @(posedge i_clk_sys);
        o_jtag.trst_n <= v;
    endtask : set_trst
    // each test clock phase spans at least two system clocks so the sampler sees it
    task automatic bit_op(input logic tms, input logic tdi, output logic [1:0] seen);
        @(posedge i_clk_sys);
        o_jtag.tms <= tms;
        o_jtag.tdi <= tdi;
        #1 seen = {i_tdo_oe, i_tdo};
        @(posedge i_clk_sys);
        o_jtag.tck <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        o_jtag.tck <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        o_jtag.tms <= 1'b1;
        o_jtag.tdi <= 1'b1;
    endtask : bit_op
endmodule : jtag_host

// file: sim/tb_top.sv
// testbench: strap sweep, lock wait, register port, shared pin and test port
`timescale 1ns/1ps
module tb_top;
    import clk_rst_pkg::*;
    localparam int          LW = 8;
    localparam logic [31:0] RV = 32'h0000_0100;
    logic        i_clk_sys, i_rstn, core_rstn, start, clk_pll, pin, tdo, tdo_oe, p;
    logic [1:0]  straps, div, seen;
    logic [5:0]  mult;
    logic [31:0] rdata, vec, rd_v;
    bus_req_t    bus;
    jtag_in_t    jtag;
    int          errors, num_checks;
    logic [5:0]  mult_tab [4] = '{MULT_3, MULT_16, MULT_8, MULT_BYPASS};
    clock_reset_sequencer #(.LOCK_WAIT(LW), .RESET_VECTOR(RV)) dut (
        .i_clk_sys, .i_rstn, .i_ratio_select_pins(straps), .i_bus(bus), .i_jtag(jtag), .o_rdata(rdata),
        .o_core_rstn(core_rstn), .o_exec_start(start), .o_exec_vector(vec), .o_core_clk_pll(clk_pll),
        .o_pll_mult(mult), .o_pll_div(div), .o_shared_out_pin(pin), .o_tdo(tdo), .o_tdo_oe(tdo_oe));
    jtag_host host (.i_clk_sys, .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_jtag(jtag));
    initial
    begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk_sys);
        bus.wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clk_sys);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial
    begin
        i_rstn = 1'b0;
        straps = 2'h0;
        bus = '0;
        for (int s = 0; s < 4; s++)
        begin
            @(posedge i_clk_sys);
            i_rstn <= 1'b0;
            straps <= 2'(s);
            repeat (9) @(posedge i_clk_sys);
            #1 check("reset", {core_rstn, pin, start, clk_pll, div, mult}, {4'h1, DIV_RESET, MULT_3});
            @(posedge i_clk_sys);
            i_rstn <= 1'b1;
            wr(OFS_PWR_CTL, 32'h0000_002a);
            #1 check("strap", {clk_pll, mult}, {s != 3, mult_tab[s]});
            rd(OFS_STATUS, rd_v);
            check("status", rd_v, {29'h0, 2'(s), 1'b0});
            repeat (LW - 4) @(posedge i_clk_sys);
            #1 check("lock", {core_rstn, pin}, 2'h0);
            @(posedge i_clk_sys);
            #1 check("run", {core_rstn, pin, start}, 3'h7);
            check("vector", vec, RV);
            @(posedge i_clk_sys);
            #1 check("pulse", start, 1'b0);
            $display("strap test %0d done", s);
        end
        wr(OFS_PWR_CTL, 32'h0000_1185);
        #1 check("pll", {clk_pll, div, mult}, {1'b1, 2'h2, 6'h05});
        @(posedge i_clk_sys);
        #1 p = pin;
        @(posedge i_clk_sys);
        #1 check("pin clock", pin, !p);
        wr(OFS_PWR_CTL, 32'h0000_0185);
        @(posedge i_clk_sys);
        #1 check("pin reset", pin, 1'b1);
        // a second look rules out a clock that happens to be high
        @(posedge i_clk_sys);
        #1 check("pin reset", pin, 1'b1);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, rd_v);
        check("unmapped", rd_v, 32'h0);
        check("unmapped pll", {div, mult}, {2'h2, 6'h05});
        rd(OFS_PWR_CTL, rd_v);
        check("control", rd_v, 32'h0000_0185);
        $display("register test done");
        host.set_trst(1'b1);
        for (int i = 0; i < 4; i++)
            host.bit_op(1'(4'b0010 >> i), 1'b1, seen);
        for (int j = 0; j < 16; j++)
            host.bit_op(1'b0, 1'(16'hc35a >> j), seen);
        for (int j = 0; j < 16; j++)
        begin
            host.bit_op(1'b0, 1'b0, seen);
            check("scan", seen, {1'b1, 1'(16'hc35a >> j)});
        end
        // mode select stays low, so only the test reset can stop the shifting
        host.set_trst(1'b0);
        for (int k = 0; k < 2; k++)
        begin
            host.bit_op(1'b0, 1'b1, seen);
            check("test reset", seen[1], 1'b0);
        end
        $display("test port test done");
        conclude();
    end
    initial
    begin
        repeat (5000) @(posedge i_clk_sys);
        errors++;
        $display("unexpected run length: expected done seen hang");
        conclude();
    end
endmodule : tb_top
